// File: rtl/ecs_map.svh
`ifndef ECS_MAP_SVH
`define ECS_MAP_SVH

// Parameter numbers of the clock block
`define ECS_ADDR_W 16
`define ECS_ADDR_EXT_SELECT 16'h4E84
`define ECS_ADDR_TERMINATION 16'h4E98
`define ECS_ADDR_EXT_RANGE 16'h4EA2
`define ECS_ADDR_EXT_DIVIDER 16'h4E48

// Field widths
`define ECS_DATA_W 32
`define ECS_RANGE_W 6
`define ECS_DIV_W 11

// External range encodings
`define ECS_RANGE_SINGLE 6'h02
`define ECS_RANGE_BURST_SMALL 6'h04
`define ECS_RANGE_BURST_MEDIUM 6'h08
`define ECS_RANGE_BURST_LARGE 6'h10
`define ECS_RANGE_BURST_XLARGE 6'h20

// Divider values that are accepted
`define ECS_DIV_1 11'h001
`define ECS_DIV_2 11'h002
`define ECS_DIV_4 11'h004
`define ECS_DIV_8 11'h008
`define ECS_DIV_10 11'h00A
`define ECS_DIV_16 11'h010
`define ECS_DIV_20 11'h014
`define ECS_DIV_40 11'h028
`define ECS_DIV_50 11'h032
`define ECS_DIV_80 11'h050
`define ECS_DIV_100 11'h064
`define ECS_DIV_200 11'h0C8
`define ECS_DIV_400 11'h190
`define ECS_DIV_500 11'h1F4
`define ECS_DIV_800 11'h320
`define ECS_DIV_1000 11'h3E8
`define ECS_DIV_2000 11'h7D0

// Channel patterns
`define ECS_CH_ONLY0 4'h1
`define ECS_CH_0_1 4'h3
`define ECS_CH_0_2 4'h5
`define ECS_CH_ALL 4'hF

// Reset values
`define ECS_RST_SELECT 1'h0
`define ECS_RST_TERMINATION 1'h0
`define ECS_RST_RANGE `ECS_RANGE_SINGLE
`define ECS_RST_DIVIDER `ECS_DIV_1

`endif

// File: rtl/ecs_pkg.sv
package ecs_pkg;

  // Channel setups that share one set of range limits
  typedef enum logic [1:0] {
    ECS_CFG_WIDE,
    ECS_CFG_MID,
    ECS_CFG_NARROW,
    ECS_CFG_UNKNOWN
  } ecs_chcfg_e;

endpackage

// File: rtl/ecs_div_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "ecs_map.svh"

interface ecs_div_if;
  logic run;
  logic in_rise;
  logic in_level;
  logic [`ECS_DIV_W-1:0] divisor;
  logic out_tick;
  logic out_level;

  modport ctl (
    output run,
    output in_rise,
    output in_level,
    output divisor,
    input out_tick,
    input out_level
  );

  modport div (
    input run,
    input in_rise,
    input in_level,
    input divisor,
    output out_tick,
    output out_level
  );
endinterface // ecs_div_if

`default_nettype wire

// File: rtl/ecs_clk_div.sv
`timescale 1ns/10ps
`default_nettype none
`include "ecs_map.svh"

module ecs_clk_div (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Divider link
  ecs_div_if.div dp
);

  logic [`ECS_DIV_W-1:0] cnt_r;
  logic last;

  // A shrunken divisor wraps at once instead of running to the top
  assign last = (cnt_r >= dp.divisor - `ECS_DIV_1);

  // Counts edges only; no time limit, so a stopped clock simply holds
  always_ff @(posedge clock) begin
    if (srst || !dp.run) begin
      cnt_r <= '0;
    end else if (dp.in_rise) begin
      cnt_r <= last ? '0 : cnt_r + `ECS_DIV_1;
    end
  end

  assign dp.out_tick = dp.run && dp.in_rise && last;
  assign dp.out_level = (dp.divisor == `ECS_DIV_1) ? dp.in_level
                        : (cnt_r < (dp.divisor >> 1));

  a_div_wrap_tick: assert property (@(posedge clock) disable iff (srst)
    dp.run && dp.in_rise && cnt_r == dp.divisor - `ECS_DIV_1 |-> dp.out_tick)
    else $error("divider missed its wrap tick");

  a_div_restart: assert property (@(posedge clock) disable iff (srst)
    dp.out_tick |=> cnt_r == '0)
    else $error("divider count not restarted after tick");

endmodule // ecs_clk_div

`default_nettype wire

// File: rtl/ecs_top.sv
// What this block does
// - External clock select at 1 takes the sample clock from the clock connector, else internal.
// - Termination at 1 switches on the 50 Ohm load only while the connector is an input.
// - External clock is accepted at any rate down to DC, with no lower limit.
// - The external range holds one of single 2, burst small 4, medium 8, large, xlarge 32.
// - Channel 0 alone, or 0 and 2 in standard mode, allows only single or burst small.
// - Channels 0 and 1, 0 and 2 in FIFO mode, or all four in standard use the five ranges.
// - All four channels in FIFO mode use the five ranges with lower limits; the range check accepts all five with no lower limit.
// - The divider splits the external clock by a fixed value to make the sample clock.
// - The divider setting takes only 1 2 4 8 10 16 20 40 50 80 100 200 400 500 800 1000 2000.
`timescale 1ns/10ps
`default_nettype none
`include "ecs_map.svh"

module ecs_top (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Parameter access
  input wire logic param_wr_en,
  input wire logic param_rd_en,
  input wire logic [`ECS_ADDR_W-1:0] param_addr,
  input wire logic [`ECS_DATA_W-1:0] param_wdata,
  output logic [`ECS_DATA_W-1:0] param_rdata_r,
  output logic param_ack_r,
  output logic param_err_r,
  // Board setup
  input wire logic [3:0] chan_enable,
  input wire logic fifo_mode,
  // Clock sources
  input wire logic ext_clk_pin,
  input wire logic int_sample_clk,
  // Connector and sample clock
  output logic term_enable_r,
  output logic sample_clk_r,
  output logic sample_tick_r,
  output logic range_mismatch_r
);

  function automatic logic addr_mapped(input logic [`ECS_ADDR_W-1:0] a);
    addr_mapped = (a == `ECS_ADDR_EXT_SELECT) || (a == `ECS_ADDR_TERMINATION) ||
                  (a == `ECS_ADDR_EXT_RANGE) || (a == `ECS_ADDR_EXT_DIVIDER);
  endfunction

  function automatic logic range_code_ok(input logic [`ECS_DATA_W-1:0] v);
    logic [`ECS_RANGE_W-1:0] c;
    c = v[`ECS_RANGE_W-1:0];
    range_code_ok = (v[`ECS_DATA_W-1:`ECS_RANGE_W] == '0) &&
                    (c == `ECS_RANGE_SINGLE || c == `ECS_RANGE_BURST_SMALL ||
                     c == `ECS_RANGE_BURST_MEDIUM || c == `ECS_RANGE_BURST_LARGE ||
                     c == `ECS_RANGE_BURST_XLARGE);
  endfunction

  function automatic logic div_code_ok(input logic [`ECS_DATA_W-1:0] v);
    logic [`ECS_DIV_W-1:0] d;
    d = v[`ECS_DIV_W-1:0];
    div_code_ok = 1'b0;
    if (v[`ECS_DATA_W-1:`ECS_DIV_W] == '0) begin
      case (d)
        `ECS_DIV_1, `ECS_DIV_2, `ECS_DIV_4, `ECS_DIV_8, `ECS_DIV_10, `ECS_DIV_16,
        `ECS_DIV_20, `ECS_DIV_40, `ECS_DIV_50, `ECS_DIV_80, `ECS_DIV_100,
        `ECS_DIV_200, `ECS_DIV_400, `ECS_DIV_500, `ECS_DIV_800, `ECS_DIV_1000,
        `ECS_DIV_2000: div_code_ok = 1'b1;
        default: div_code_ok = 1'b0;
      endcase
    end
  endfunction

  function automatic ecs_pkg::ecs_chcfg_e classify(input logic [3:0] ch, input logic fifo);
    classify = ecs_pkg::ECS_CFG_UNKNOWN;
    if (ch == `ECS_CH_ONLY0 || (ch == `ECS_CH_0_2 && !fifo)) begin
      classify = ecs_pkg::ECS_CFG_WIDE;
    end else if (ch == `ECS_CH_0_1 || (ch == `ECS_CH_0_2 && fifo) ||
                 (ch == `ECS_CH_ALL && !fifo)) begin
      classify = ecs_pkg::ECS_CFG_MID;
    end else if (ch == `ECS_CH_ALL && fifo) begin
      classify = ecs_pkg::ECS_CFG_NARROW;
    end
  endfunction

  function automatic logic range_allowed(input ecs_pkg::ecs_chcfg_e cfg,
                                         input logic [`ECS_RANGE_W-1:0] r);
    case (cfg)
      ecs_pkg::ECS_CFG_WIDE: begin
        range_allowed = (r == `ECS_RANGE_SINGLE) || (r == `ECS_RANGE_BURST_SMALL);
      end
      ecs_pkg::ECS_CFG_MID, ecs_pkg::ECS_CFG_NARROW: range_allowed = 1'b1;
      default: range_allowed = 1'b1;
    endcase
  endfunction

  // Stored settings
  logic ext_sel_r;
  logic term_r;
  logic [`ECS_RANGE_W-1:0] range_r;
  logic [`ECS_DIV_W-1:0] div_r;

  logic wr_ok;
  logic req;
  ecs_pkg::ecs_chcfg_e cfg;

  always_comb begin
    wr_ok = 1'b0;
    case (param_addr)
      `ECS_ADDR_EXT_SELECT: wr_ok = 1'b1;
      `ECS_ADDR_TERMINATION: wr_ok = 1'b1;
      `ECS_ADDR_EXT_RANGE: wr_ok = range_code_ok(param_wdata);
      `ECS_ADDR_EXT_DIVIDER: wr_ok = div_code_ok(param_wdata);
      default: wr_ok = 1'b0;
    endcase
  end

  assign req = param_wr_en || param_rd_en;
  assign cfg = classify(chan_enable, fifo_mode);

  // Illegal codes leave the stored value untouched
  always_ff @(posedge clock) begin
    if (srst) begin
      ext_sel_r <= `ECS_RST_SELECT;
      term_r <= `ECS_RST_TERMINATION;
      range_r <= `ECS_RST_RANGE;
      div_r <= `ECS_RST_DIVIDER;
    end else if (param_wr_en && wr_ok) begin
      case (param_addr)
        `ECS_ADDR_EXT_SELECT: ext_sel_r <= param_wdata[0];
        `ECS_ADDR_TERMINATION: term_r <= param_wdata[0];
        `ECS_ADDR_EXT_RANGE: range_r <= param_wdata[`ECS_RANGE_W-1:0];
        `ECS_ADDR_EXT_DIVIDER: div_r <= param_wdata[`ECS_DIV_W-1:0];
        default: ext_sel_r <= ext_sel_r;
      endcase
    end
  end

  // Parameter answers
  always_ff @(posedge clock) begin
    if (srst) begin
      param_ack_r <= 1'b0;
      param_err_r <= 1'b0;
      param_rdata_r <= '0;
    end else begin
      param_ack_r <= req;
      param_err_r <= req && (!addr_mapped(param_addr) || (param_wr_en && !wr_ok));
      if (param_rd_en && !param_wr_en) begin
        case (param_addr)
          `ECS_ADDR_EXT_SELECT: param_rdata_r <= {{(`ECS_DATA_W-1){1'b0}}, ext_sel_r};
          `ECS_ADDR_TERMINATION: param_rdata_r <= {{(`ECS_DATA_W-1){1'b0}}, term_r};
          `ECS_ADDR_EXT_RANGE: begin
            param_rdata_r <= {{(`ECS_DATA_W-`ECS_RANGE_W){1'b0}}, range_r};
          end
          `ECS_ADDR_EXT_DIVIDER: begin
            param_rdata_r <= {{(`ECS_DATA_W-`ECS_DIV_W){1'b0}}, div_r};
          end
          default: param_rdata_r <= '0;
        endcase
      end
    end
  end

  // Connector pin synchroniser; only slow clocks survive sampling at 10 MHz
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic int_q_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_clk_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      int_q_r <= 1'b0;
    end else begin
      int_q_r <= int_sample_clk;
    end
  end

  ecs_div_if dif ();

  // Divider held in reset while internal clock is chosen
  assign dif.run = ext_sel_r;
  assign dif.in_rise = ext_s2_r && !ext_s3_r;
  assign dif.in_level = ext_s2_r;
  assign dif.divisor = div_r;

  ecs_clk_div u_div (
    .clock(clock),
    .srst(srst),
    .dp(dif)
  );

  // Source switch is not glitch free; change it only while stopped
  always_ff @(posedge clock) begin
    if (srst) begin
      sample_clk_r <= 1'b0;
      sample_tick_r <= 1'b0;
    end else if (ext_sel_r) begin
      sample_clk_r <= dif.out_level;
      sample_tick_r <= dif.out_tick;
    end else begin
      sample_clk_r <= int_sample_clk;
      sample_tick_r <= int_sample_clk && !int_q_r;
    end
  end

  // Load only while the connector faces inward
  always_ff @(posedge clock) begin
    if (srst) begin
      term_enable_r <= 1'b0;
    end else begin
      term_enable_r <= term_r && ext_sel_r;
    end
  end

  // Setup check; the rate itself is the source's duty
  always_ff @(posedge clock) begin
    if (srst) begin
      range_mismatch_r <= 1'b0;
    end else begin
      range_mismatch_r <= ext_sel_r && !range_allowed(cfg, range_r);
    end
  end

  sequence s_div_write_bad;
    param_wr_en && param_addr == `ECS_ADDR_EXT_DIVIDER && !div_code_ok(param_wdata);
  endsequence

  sequence s_range_write_bad;
    param_wr_en && param_addr == `ECS_ADDR_EXT_RANGE && !range_code_ok(param_wdata);
  endsequence

  sequence s_ext_edge;
    ext_sel_r && dif.out_tick;
  endsequence

  // Internal mode still stores legal codes for a later switch
  sequence s_range_write_ok;
    param_wr_en && param_addr == `ECS_ADDR_EXT_RANGE && range_code_ok(param_wdata);
  endsequence

  a_ext_tick_route: assert property (@(posedge clock) disable iff (srst)
    s_ext_edge |=> sample_tick_r)
    else $error("external tick not passed to sample clock");

  a_int_tick_route: assert property (@(posedge clock) disable iff (srst)
    !ext_sel_r && int_sample_clk && !int_q_r ##1 !ext_sel_r |-> sample_tick_r)
    else $error("internal tick not passed to sample clock");

  a_term_gating: assert property (@(posedge clock) disable iff (srst)
    term_enable_r |-> $past(term_r) && $past(ext_sel_r))
    else $error("termination on while connector not an input");

  a_range_code_kept: assert property (@(posedge clock) disable iff (srst)
    s_range_write_bad |=> $stable(range_r) && param_err_r)
    else $error("illegal range code taken");

  a_div_code_kept: assert property (@(posedge clock) disable iff (srst)
    s_div_write_bad |=> $stable(div_r) && param_err_r)
    else $error("illegal divider value taken");

  a_div_always_legal: assert property (@(posedge clock) disable iff (srst)
    div_code_ok({{(`ECS_DATA_W-`ECS_DIV_W){1'b0}}, div_r}))
    else $error("divider register holds an illegal value");

  a_wide_mismatch: assert property (@(posedge clock) disable iff (srst)
    ext_sel_r && cfg == ecs_pkg::ECS_CFG_WIDE && range_r == `ECS_RANGE_BURST_MEDIUM
    |=> range_mismatch_r)
    else $error("wide setup with medium range not flagged");

  a_int_mode_quiet: assert property (@(posedge clock) disable iff (srst)
    !ext_sel_r ##1 !ext_sel_r [*2] |-> !range_mismatch_r && !dif.out_tick)
    else $error("external settings acted in internal mode");

  a_sel_write: assert property (@(posedge clock) disable iff (srst)
    param_wr_en && param_addr == `ECS_ADDR_EXT_SELECT |=> ext_sel_r == $past(param_wdata[0]))
    else $error("select write not stored");

  a_term_off_internal: assert property (@(posedge clock) disable iff (srst)
    !ext_sel_r |=> !term_enable_r)
    else $error("termination on with internal clock");

  a_mid_no_mismatch: assert property (@(posedge clock) disable iff (srst)
    ext_sel_r && cfg != ecs_pkg::ECS_CFG_WIDE |=> !range_mismatch_r)
    else $error("five range setup flagged as mismatch");

  a_range_kept_internal: assert property (@(posedge clock) disable iff (srst)
    s_range_write_ok ##0 !ext_sel_r |=> range_r == $past(param_wdata[`ECS_RANGE_W-1:0]))
    else $error("range not stored in internal mode");

  a_param_answer: assert property (@(posedge clock) disable iff (srst)
    req |=> param_ack_r ##0 (param_err_r == $past(req && !addr_mapped(param_addr)) ||
                             $past(param_wr_en)))
    else $error("parameter access not answered");

endmodule // ecs_top

`default_nettype wire

// File: test/ecs_ext_src.sv
`timescale 1ns/10ps
`default_nettype none

module ecs_ext_src (
  // Clock connector
  output logic pin
);
  // Parks low between bursts, so every burst starts from a clean rising edge
  initial pin = 1'h0;

  // Steady half period; callers keep it inside the chosen range and rate limit
  task automatic burst(input int n, input int half_ns);
    repeat (n) begin
      #(half_ns) pin = 1'h1;
      #(half_ns) pin = 1'h0;
    end
  endtask
endmodule // ecs_ext_src

`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "ecs_map.svh"

module testbench;
  logic clock, srst, wr_en, rd_en, fifo_mode, int_clk;
  logic [15:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] chan;
  logic ack, err, term, sclk, tick, mism, pin, sclk_q;
  int n_mismatch, checks_done, n_tick, n_srise, seed, cyc;
  typedef struct {logic [31:0] d; logic e; logic rd;} ecs_note_s;
  ecs_note_s notes[$];
  logic [10:0] dl[17] = '{11'h001, 11'h002, 11'h004, 11'h008, 11'h00A, 11'h010, 11'h014,
    11'h028, 11'h032, 11'h050, 11'h064, 11'h0C8, 11'h190, 11'h1F4, 11'h320, 11'h3E8, 11'h7D0};
  logic [5:0] rc[5] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
  logic [3:0] chs[5] = '{4'h1, 4'h5, 4'h5, 4'h3, 4'hF};
  logic mf[5] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1};
  logic me[5] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0};

  ecs_top uut (.clock(clock), .srst(srst), .param_wr_en(wr_en), .param_rd_en(rd_en),
    .param_addr(addr), .param_wdata(wdata), .param_rdata_r(rdata), .param_ack_r(ack),
    .param_err_r(err), .chan_enable(chan), .fifo_mode(fifo_mode), .ext_clk_pin(pin),
    .int_sample_clk(int_clk), .term_enable_r(term), .sample_clk_r(sclk),
    .sample_tick_r(tick), .range_mismatch_r(mism));

  ecs_ext_src src (.pin(pin));

  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One request, then an idle cycle so no strobe is set twice in a time step
  task automatic req(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic e);
    notes.push_back('{x, e, ~w});
    wr_en = w;
    rd_en = ~w;
    addr = a;
    wdata = d;
    @(negedge clock);
    wr_en = 1'h0;
    rd_en = 1'h0;
    @(negedge clock);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
    req(1'h1, a, d, 32'h0, e);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic e);
    req(1'h0, a, 32'h0, x, e);
  endtask

  // Sampled mid-cycle, away from the edge that moves the outputs
  always @(negedge clock) begin
    if (tick === 1'h1) n_tick++;
    if (sclk === 1'h1 && sclk_q === 1'h0) n_srise++;
    sclk_q = sclk;
  end

  // One settled cycle first, so a level change from the last write is not counted
  task automatic clear_counts;
    @(negedge clock);
    n_tick = 0;
    n_srise = 0;
  endtask

  // Answers are matched in order against the notes left by the driver
  always @(negedge clock) begin
    ecs_note_s n;
    if (ack === 1'h1) begin
      if (notes.size() == 0) begin
        chk("spare ack", 32'h1, 32'h0);
      end else begin
        n = notes.pop_front();
        chk("param_err_r", 32'(err), 32'(n.e));
        if (n.rd) chk("param_rdata_r", rdata, n.d);
      end
    end
    cyc++;
    if (cyc >= 30000) begin
      n_mismatch++;
      print_verdict;
    end
  end

  initial begin
    logic [10:0] v, last;
    logic ok;
    int nd;
    seed = 13;
    srst = 1'h1;
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr = 16'h0000;
    wdata = 32'h0;
    chan = 4'h1;
    fifo_mode = 1'h0;
    int_clk = 1'h0;
    repeat (2) @(negedge clock);
    srst = 1'h0;
    rd(`ECS_ADDR_EXT_SELECT, 32'h0, 1'h0);
    rd(`ECS_ADDR_TERMINATION, 32'h0, 1'h0);
    rd(`ECS_ADDR_EXT_RANGE, 32'(`ECS_RANGE_SINGLE), 1'h0);
    rd(`ECS_ADDR_EXT_DIVIDER, 32'(`ECS_DIV_1), 1'h0);
    rd(16'h0001, 32'h0, 1'h1);
    foreach (rc[i]) begin
      wr(`ECS_ADDR_EXT_RANGE, 32'(rc[i]), 1'h0);
      rd(`ECS_ADDR_EXT_RANGE, 32'(rc[i]), 1'h0);
    end
    wr(`ECS_ADDR_EXT_RANGE, 32'h3, 1'h1);
    wr(`ECS_ADDR_EXT_RANGE, 32'h102, 1'h1);
    rd(`ECS_ADDR_EXT_RANGE, 32'h20, 1'h0);
    foreach (dl[i]) begin
      wr(`ECS_ADDR_EXT_DIVIDER, 32'(dl[i]), 1'h0);
      rd(`ECS_ADDR_EXT_DIVIDER, 32'(dl[i]), 1'h0);
    end
    last = 11'h7D0;
    repeat (20) begin
      v = 11'($random(seed));
      ok = 1'h0;
      foreach (dl[i]) if (dl[i] === v) ok = 1'h1;
      if (ok) last = v;
      wr(`ECS_ADDR_EXT_DIVIDER, 32'(v), ~ok);
    end
    rd(`ECS_ADDR_EXT_DIVIDER, 32'(last), 1'h0);
    wr(`ECS_ADDR_TERMINATION, 32'h1, 1'h0);
    chk("term_enable_r", 32'(term), 32'h0);
    wr(`ECS_ADDR_EXT_SELECT, 32'h1, 1'h0);
    chk("term_enable_r", 32'(term), 32'h1);
    foreach (chs[i]) begin
      chan = chs[i];
      fifo_mode = mf[i];
      wr(`ECS_ADDR_EXT_RANGE, 32'h8, 1'h0);
      chk("range_mismatch_r", 32'(mism), 32'(me[i]));
      wr(`ECS_ADDR_EXT_RANGE, 32'h4, 1'h0);
      chk("range_mismatch_r", 32'(mism), 32'h0);
    end
    // Divisor changes only between whole bursts, so the count sits at zero
    repeat (4) begin
      nd = ($random(seed) & 32'h7) % 6;
      wr(`ECS_ADDR_EXT_DIVIDER, 32'(dl[nd]), 1'h0);
      clear_counts;
      src.burst(3 * int'(dl[nd]), 400);
      repeat (10) @(negedge clock);
      chk("ext ticks", 32'(n_tick), 32'h3);
      chk("ext clock periods", 32'(n_srise), 32'h3);
    end
    wr(`ECS_ADDR_EXT_DIVIDER, 32'h1, 1'h0);
    clear_counts;
    src.burst(2, 2000);
    repeat (10) @(negedge clock);
    chk("slow ticks", 32'(n_tick), 32'h2);
    chk("slow clock periods", 32'(n_srise), 32'h2);
    chan = 4'h1;
    fifo_mode = 1'h0;
    wr(`ECS_ADDR_EXT_RANGE, 32'h8, 1'h0);
    wr(`ECS_ADDR_EXT_SELECT, 32'h0, 1'h0);
    chk("range_mismatch_r", 32'(mism), 32'h0);
    clear_counts;
    fork
      src.burst(7, 400);
      repeat (5) begin
        int_clk = 1'h1;
        repeat (3) @(negedge clock);
        int_clk = 1'h0;
        repeat (3) @(negedge clock);
      end
    join
    repeat (10) @(negedge clock);
    chk("int ticks", 32'(n_tick), 32'h5);
    chk("int clock periods", 32'(n_srise), 32'h5);
    rd(`ECS_ADDR_EXT_RANGE, 32'h8, 1'h0);
    rd(`ECS_ADDR_EXT_DIVIDER, 32'(`ECS_DIV_1), 1'h0);
    print_verdict;
  end
endmodule // testbench

`default_nettype wire
